// ==== core/osd_display_memory_access.sv ====
// display memory registers, write path, zero clear and background select
//
// Overview of operation
// - video background only external sync, both bits clear
// - address-high written at 05H, read at 85H
// - address-low written at 06H, read at 86H
// - data-in written at 07H, read at 87H
// - glyph command written at 08H, read at 88H
// - 8-bit mode: byte-select picks code or attribute
// - location is address-high bit 0 plus address-low
// - attribute byte: background, blink, invert in 7:5
// - 16-bit mode always stores data-in as code
// - FFH during auto-increment ends it, not stored
// - FFH stored normally outside auto-increment
// - data-in write stores code or attribute byte
// - auto-increment starts at current address, then increments
// - clear busy drops by itself after the full clear time
`include "osd_dm_defs.svh"
module osd_display_memory_access
  import osd_dm_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       mode_8bit,
  input  wire logic       auto_inc_enable,
  input  wire logic       clear_request,
  input  wire logic [2:0] default_attr,
  input  wire logic       nvm_busy,
  input  wire logic       overlay_enable,
  input  wire logic       background_mode,
  input  wire logic       sync_external,
  output logic            clear_busy,
  output logic            auto_inc_active,
  output logic            auto_inc_escape,
  output logic      [7:0] glyph_memory_command,
  input  wire char_loc_t  view_addr,
  output logic      [7:0] view_code,
  output logic      [2:0] view_attr,
  output logic            view_bg_video
);
  logic [7:0] character_code_mem [`MEM_WORDS];
  logic [2:0] attr_mem           [`MEM_WORDS];

  logic [7:0] display_addr_high;
  logic [7:0] display_addr_low;
  logic [7:0] display_data_in;
  logic       auto_req_seen;
  char_loc_t  auto_ptr;

  logic [7:0] next_display_addr_high;
  logic [7:0] next_display_addr_low;
  logic [7:0] next_display_data_in;
  logic [7:0] next_glyph_memory_command;
  logic       next_auto_inc_active;
  logic       next_auto_req_seen;
  char_loc_t  next_auto_ptr;
  logic [7:0] next_reg_rdata;
  logic       next_auto_inc_escape;
  logic [7:0] next_view_code;
  logic [2:0] next_view_attr;
  logic       next_view_bg_video;

  logic       fill_we;
  char_loc_t  fill_addr;
  logic       host_ok;
  logic       wr_high;
  logic       wr_low;
  logic       wr_data;
  logic       wr_glyph;
  logic       is_escape;
  logic       store;
  logic       store_attr;
  char_loc_t  store_loc;
  logic       code_we;
  logic       attr_we;
  char_loc_t  mem_loc;
  logic [7:0] code_wdata;
  logic [2:0] attr_wdata;

  display_clear_timer u_clear (
    .mclk      (mclk),
    .rst       (rst),
    .start     (clear_request),
    .busy      (clear_busy),
    .fill_we   (fill_we),
    .fill_addr (fill_addr)
  );

  // write decode and store path
  always_comb begin
    host_ok    = reg_wr && !clear_busy;
    wr_high    = host_ok && (reg_addr == `WR_ADDR_HIGH);
    wr_low     = host_ok && (reg_addr == `WR_ADDR_LOW);
    wr_data    = host_ok && (reg_addr == `WR_DATA_IN);
    wr_glyph   = reg_wr && (reg_addr == `WR_GLYPH_CMD)
                 && !nvm_busy && !overlay_enable;
    is_escape  = auto_inc_active && (reg_wdata == `ESCAPE_CODE);
    store      = wr_data && !is_escape;
    // 16-bit mode ignores the byte select entirely
    store_attr = mode_8bit
                 && display_addr_high[`AH_BYTE_SEL_BIT];
    store_loc  = auto_inc_active ? auto_ptr
                 : {display_addr_high[`AH_MSB_BIT],
                    display_addr_low};
  end

  // register next values
  always_comb begin
    next_display_addr_high    = display_addr_high;
    next_display_addr_low     = display_addr_low;
    next_display_data_in      = display_data_in;
    next_glyph_memory_command = glyph_memory_command;
    next_auto_inc_active      = auto_inc_active;
    next_auto_req_seen        = auto_inc_enable;
    next_auto_ptr             = auto_ptr;
    next_auto_inc_escape      = wr_data && is_escape;
    if (wr_high) next_display_addr_high = reg_wdata;
    if (wr_low) next_display_addr_low = reg_wdata;
    if (wr_data) next_display_data_in = reg_wdata;
    if (wr_glyph) next_glyph_memory_command = reg_wdata;
    if (auto_inc_enable && !auto_req_seen) begin
      next_auto_inc_active = 1'b1;
      next_auto_ptr = {display_addr_high[`AH_MSB_BIT],
                       display_addr_low};
    end else if (!auto_inc_enable || (wr_data && is_escape)) begin
      next_auto_inc_active = 1'b0;
    end else if (store) begin
      // wraps from 511 to 0; host keeps strings within the screen
      next_auto_ptr = auto_ptr + 9'h001;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        `RD_ADDR_HIGH: next_reg_rdata = display_addr_high;
        `RD_ADDR_LOW:  next_reg_rdata = display_addr_low;
        `RD_DATA_IN:   next_reg_rdata = display_data_in;
        `RD_GLYPH_CMD: next_reg_rdata = glyph_memory_command;
        default:       next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      display_addr_high    <= `RST_ADDR_HIGH;
      display_addr_low     <= `RST_ADDR_LOW;
      display_data_in      <= `RST_DATA_IN;
      glyph_memory_command <= `RST_GLYPH_CMD;
      auto_inc_active      <= 1'b0;
      auto_req_seen        <= 1'b0;
      auto_ptr             <= 9'h000;
      reg_rdata            <= 8'h00;
      auto_inc_escape      <= 1'b0;
    end else begin
      display_addr_high    <= next_display_addr_high;
      display_addr_low     <= next_display_addr_low;
      display_data_in      <= next_display_data_in;
      glyph_memory_command <= next_glyph_memory_command;
      auto_inc_active      <= next_auto_inc_active;
      auto_req_seen        <= next_auto_req_seen;
      auto_ptr             <= next_auto_ptr;
      reg_rdata            <= next_reg_rdata;
      auto_inc_escape      <= next_auto_inc_escape;
    end
  end

  // memory write port; clear and host never overlap, host is held off
  always_comb begin
    code_we    = 1'b0;
    attr_we    = 1'b0;
    mem_loc    = store_loc;
    code_wdata = reg_wdata;
    attr_wdata = default_attr;
    if (fill_we) begin
      code_we    = 1'b1;
      attr_we    = 1'b1;
      mem_loc    = fill_addr;
      code_wdata = 8'h00;
      attr_wdata = 3'h0;
    end else if (store && store_attr) begin
      attr_we    = 1'b1;
      attr_wdata = {reg_wdata[`ATTR_LBC_BIT],
                    reg_wdata[`ATTR_BLK_BIT],
                    reg_wdata[`ATTR_INV_BIT]};
    end else if (store) begin
      code_we = 1'b1;
      // 16-bit mode writes the attribute along with the code
      attr_we = !mode_8bit;
    end
  end

  always_ff @(posedge mclk) begin
    if (code_we) character_code_mem[mem_loc] <= code_wdata;
    if (attr_we) attr_mem[mem_loc] <= attr_wdata;
  end

  // display read port, one cycle latency
  always_comb begin
    next_view_code     = character_code_mem[view_addr];
    next_view_attr     = attr_mem[view_addr];
    // attr bit 2 is the local background bit
    next_view_bg_video = sync_external && !background_mode
                         && !next_view_attr[2];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      view_code     <= 8'h00;
      view_attr     <= 3'h0;
      view_bg_video <= 1'b0;
    end else begin
      view_code     <= next_view_code;
      view_attr     <= next_view_attr;
      view_bg_video <= next_view_bg_video;
    end
  end
endmodule

// ==== common/osd_dm_defs.svh ====
// register addresses, field positions and timing counts for display memory
`ifndef OSD_DM_DEFS_SVH
`define OSD_DM_DEFS_SVH

`define WR_ADDR_HIGH      8'h05
`define WR_ADDR_LOW       8'h06
`define WR_DATA_IN        8'h07
`define WR_GLYPH_CMD      8'h08
`define RD_ADDR_HIGH      8'h85
`define RD_ADDR_LOW       8'h86
`define RD_DATA_IN        8'h87
`define RD_GLYPH_CMD      8'h88

`define RST_ADDR_HIGH     8'h00
`define RST_ADDR_LOW      8'h00
`define RST_DATA_IN       8'h00
`define RST_GLYPH_CMD     8'h00

`define AH_MSB_BIT        0
`define AH_BYTE_SEL_BIT   1
`define ATTR_LBC_BIT      7
`define ATTR_BLK_BIT      6
`define ATTR_INV_BIT      5
`define ESCAPE_CODE       8'hff

`define MEM_WORDS         512
`define CLK_PERIOD_NS     20
`define CLEAR_TIME_NS     20000
`define CLEAR_CYCLES      (`CLEAR_TIME_NS / `CLK_PERIOD_NS)

`endif

// ==== common/osd_dm_pkg.sv ====
// types shared by the display memory access block
package osd_dm_pkg;
  typedef enum logic [1:0] {
    CLR_IDLE = 2'b00,
    CLR_FILL = 2'b01,
    CLR_HOLD = 2'b10
  } clear_state_t;
  typedef logic [8:0] char_loc_t;
endpackage

// ==== core/display_clear_timer.sv ====
// zero fill sequencer for display memory, busy for the documented clear time
`include "osd_dm_defs.svh"
module display_clear_timer
  import osd_dm_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire logic      start,
  output logic           busy,
  output logic           fill_we,
  output char_loc_t      fill_addr
);
  localparam logic [9:0] LAST_CYCLE = 10'(`CLEAR_CYCLES - 1);
  localparam logic [9:0] LAST_WORD  = 10'(`MEM_WORDS - 1);

  clear_state_t state;
  clear_state_t next_state;
  logic [9:0]   count;
  logic [9:0]   next_count;

  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      CLR_IDLE: begin
        if (start) begin
          next_state = CLR_FILL;
          next_count = 10'h000;
        end
      end
      CLR_FILL: begin
        next_count = count + 10'h001;
        if (count == LAST_WORD) next_state = CLR_HOLD;
      end
      CLR_HOLD: begin
        // the fill is quick; the busy flag still spans the full clear time
        next_count = count + 10'h001;
        if (count == LAST_CYCLE) next_state = CLR_IDLE;
      end
      default: next_state = CLR_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      // power-up clear runs straight out of reset
      state <= CLR_FILL;
      count <= 10'h000;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign busy      = (state != CLR_IDLE);
  assign fill_we   = (state == CLR_FILL);
  assign fill_addr = count[8:0];
endmodule

// ==== testbench/osd_dm_props.sv ====
// checker for the display memory access block ports
module osd_dm_props (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       nvm_busy,
  input wire logic       overlay_enable,
  input wire logic       background_mode,
  input wire logic       sync_external,
  input wire logic       clear_busy,
  input wire logic       auto_inc_active,
  input wire logic       auto_inc_escape,
  input wire logic [7:0] glyph_memory_command,
  input wire logic [2:0] view_attr,
  input wire logic       view_bg_video
);
  timeunit 1ns;
  timeprecision 1ns;
  int   busy_n;
  int   next_busy_n;
  logic esc_wr;
  logic g_ok;
  logic w_low;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  always_comb next_busy_n = clear_busy ? busy_n + 1 : 0;
  always_ff @(posedge mclk) busy_n <= rst ? 0 : next_busy_n;
  always_comb esc_wr = reg_wr && reg_addr == 8'h07 && reg_wdata == 8'hff
                       && auto_inc_active && !clear_busy;
  always_comb g_ok = reg_wr && reg_addr == 8'h08 && !nvm_busy
                     && !overlay_enable;
  always_comb w_low = reg_wr && reg_addr == 8'h06 && !clear_busy;
  property p_bg; view_bg_video |-> $past(sync_external)
    && !$past(background_mode) && !view_attr[2]; endproperty
  a_bg: assert property (p_bg) else $error("video background wrong");
  property p_clr_len; $fell(clear_busy) |-> busy_n == 1000; endproperty
  a_clr_len: assert property (p_clr_len) else $error("clear length");
  property p_clr_max; busy_n <= 1000; endproperty
  a_clr_max: assert property (p_clr_max) else $error("clear overrun");
  property p_esc; esc_wr |=> auto_inc_escape && !auto_inc_active; endproperty
  a_esc: assert property (p_esc) else $error("escape not seen");
  property p_esc_why; auto_inc_escape |-> $past(esc_wr); endproperty
  a_esc_why: assert property (p_esc_why) else $error("stray escape");
  property p_g_keep; $changed(glyph_memory_command) |-> $past(g_ok); endproperty
  a_g_keep: assert property (p_g_keep) else $error("glyph changed");
  property p_g_take; g_ok |=> glyph_memory_command == $past(reg_wdata);
  endproperty
  a_g_take: assert property (p_g_take) else $error("glyph not taken");
  property p_low; w_low ##2 (reg_rd && reg_addr == 8'h86)
    |=> reg_rdata == $past(reg_wdata, 3); endproperty
  a_low: assert property (p_low) else $error("low readback");
endmodule
bind osd_display_memory_access osd_dm_props u_props (.*);

// ==== testbench/osd_dm_host.sv ====
// host model driving the register strobe port
module osd_dm_host (
  input  wire logic       mclk,
  input  wire logic       clear_busy,
  input  wire logic       nvm_busy,
  input  wire logic       overlay_enable,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int tmo = 0;
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  end
  // g low lets a scenario break the access condition on purpose
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit g);
    int n;
    n = 0;
    while (g && n < 1100 && (a == 8'h08 ? nvm_busy || overlay_enable
                             : clear_busy)) begin
      @(negedge mclk);
      n++;
    end
    if (n == 1100) tmo++;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge mclk);
    reg_wr = 0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge mclk);
    reg_rd = 0;
    @(negedge mclk);
    v = reg_rdata;
  endtask
endmodule

// ==== testbench/tb_osd_display_memory_access.sv ====
// self-checking bench for the display memory access registers
module tb_osd_display_memory_access;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk, rst, reg_wr, reg_rd, mode_8bit, auto_inc_enable;
  logic       clear_request, nvm_busy, overlay_enable, background_mode;
  logic       sync_external, clear_busy, auto_inc_active, view_bg_video;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, view_code;
  logic [2:0] default_attr, view_attr;
  logic [8:0] view_addr;
  int         num_errors = 0;
  int         cmp_count = 0;
  osd_display_memory_access u_dut (.mclk, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .mode_8bit, .auto_inc_enable,
    .clear_request, .default_attr, .nvm_busy, .overlay_enable,
    .background_mode, .sync_external, .clear_busy, .auto_inc_active,
    .auto_inc_escape(), .glyph_memory_command(), .view_addr, .view_code,
    .view_attr, .view_bg_video);
  osd_dm_host u_host (.mclk, .clear_busy, .nvm_busy, .overlay_enable,
    .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  always #10 mclk = ~mclk;
  task automatic finish_test;
    num_errors += u_host.tmo;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(string n, logic [7:0] a, logic [7:0] e);
    logic [7:0] v;
    u_host.rd(a, v);
    chk(n, e, v);
  endtask
  task automatic vchk(logic [8:0] l, logic [7:0] c, logic [2:0] t);
    view_addr = l;
    @(negedge mclk);
    chk("code", c, view_code);
    chk("attr", {5'h0, t}, {5'h0, view_attr});
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (clear_busy !== 1'b0 && n < 1100) begin
      @(negedge mclk);
      n++;
    end
    if (n == 1100) num_errors++;
  endtask
  initial begin
    #1500000;
    num_errors++;
    finish_test;
  end
  initial begin
    {mclk, rst, mode_8bit, auto_inc_enable, clear_request} = 5'h08;
    {nvm_busy, overlay_enable, background_mode, sync_external} = 4'h0;
    {default_attr, view_addr} = 12'h0;
    repeat (4) @(negedge mclk);
    rst = 0;
    repeat (2) @(negedge mclk);
    wait_idle;
    rchk("addr_high", 8'h85, 8'h00);
    rchk("addr_low", 8'h86, 8'h00);
    rchk("data_in", 8'h87, 8'h00);
    rchk("glyph", 8'h88, 8'h00);
    u_host.wr(8'h05, 8'h01, 1);
    u_host.wr(8'h06, 8'h23, 1);
    rchk("addr_low", 8'h86, 8'h23);
    rchk("addr_high", 8'h85, 8'h01);
    u_host.wr(8'h07, 8'hff, 1);
    rchk("data_in", 8'h87, 8'hff);
    for (int i = 0; i < 4; i++) begin
      {sync_external, background_mode} = i[1:0];
      vchk(9'h123, 8'hff, 3'h0);
      chk("bg", {7'h0, i == 2}, {7'h0, view_bg_video});
    end
    u_host.wr(8'h05, 8'h03, 1);
    u_host.wr(8'h07, 8'h42, 1);
    vchk(9'h123, 8'h42, 3'h0);
    mode_8bit = 1;
    u_host.wr(8'h07, 8'he0, 1);
    {sync_external, background_mode} = 2'b10;
    vchk(9'h123, 8'h42, 3'h7);
    chk("bg", 8'h00, {7'h0, view_bg_video});
    u_host.wr(8'h05, 8'h01, 1);
    u_host.wr(8'h06, 8'h40, 1);
    auto_inc_enable = 1;
    @(negedge mclk);
    u_host.wr(8'h07, 8'h61, 1);
    u_host.wr(8'h07, 8'h62, 1);
    u_host.wr(8'h07, 8'hff, 1);
    chk("active", 8'h00, {7'h0, auto_inc_active});
    auto_inc_enable = 0;
    vchk(9'h140, 8'h61, 3'h0);
    vchk(9'h141, 8'h62, 3'h0);
    vchk(9'h142, 8'h00, 3'h0);
    u_host.wr(8'h08, 8'h5a, 1);
    rchk("glyph", 8'h88, 8'h5a);
    overlay_enable = 1;
    u_host.wr(8'h08, 8'ha5, 0);
    {overlay_enable, nvm_busy} = 2'b01;
    u_host.wr(8'h08, 8'ha5, 0);
    nvm_busy = 0;
    rchk("glyph", 8'h88, 8'h5a);
    clear_request = 1;
    @(negedge mclk);
    clear_request = 0;
    u_host.wr(8'h06, 8'h99, 0);
    rchk("addr_low", 8'h86, 8'h40);
    wait_idle;
    vchk(9'h141, 8'h00, 3'h0);
    finish_test;
  end
endmodule
